// File: rtl/dips_top.sv
/*
  DMA interrupt pending summary: per-channel interrupt flags, a selected-channel
  summary view, a lowest-pending locator and an event interrupt, on AHB-Lite.
  Assumes set, clear, busy and fetch-error inputs come from logic on mclk.
*/
`timescale 1ns/1ps
`default_nettype none
module dips_top
  import dips_pkg::*;
(
  input  wire logic                          mclk,
  input  wire logic                          rst_b,
  input  wire logic                          hsel,
  input  wire logic [31:0]                   haddr,
  input  wire logic [1:0]                    htrans,
  input  wire logic                          hwrite,
  input  wire logic [2:0]                    hsize,
  input  wire logic [31:0]                   hwdata,
  input  wire logic                          hready,
  output logic                               hreadyout,
  output logic                               hresp,
  output logic [31:0]                        hrdata,
  input  wire dips_pkg::dips_chvec_t         chanSet,
  input  wire dips_pkg::dips_chvec_t         chanClr,
  input  wire logic [dips_pkg::DIPS_NCH-1:0] chanBusy,
  input  wire logic [dips_pkg::DIPS_NCH-1:0] chanFetchErr,
  output dips_pkg::dips_chvec_t              chanFlags,
  output logic                               irq
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [DIPS_NCH-1:0] oneHot(input logic en, input logic [DIPS_CHW-1:0] ch);
    oneHot = en ? (DIPS_NCH'(1) << ch) : '0;
  endfunction

  // Set wins over clear so an event landing on a clear is kept
  function automatic logic [DIPS_NCH-1:0] nextFlags(input logic [DIPS_NCH-1:0] cur,
                                                    input logic [DIPS_NCH-1:0] set,
                                                    input logic [DIPS_NCH-1:0] clr);
    nextFlags = (cur & ~clr) | set;
  endfunction

  // Register write decode, applied in the data phase
  function automatic logic wrHit(input dips_aphase_t aph, input logic [7:0] addr);
    wrHit = aph.valid && aph.write && (aph.addr == addr);
  endfunction

  dips_chvec_t            flags_ff;
  dips_chvec_t            nxt_flags;
  dips_aphase_t           aph_ff;
  logic [DIPS_CHW-1:0]    id_ff;
  logic [31:0]            hrdata_ff;
  logic [DIPS_NEV-1:0]    evStat_ff;
  logic [DIPS_NEV-1:0]    evEn_ff;
  logic [DIPS_NCH-1:0]    pendVec;
  logic [DIPS_NCH-1:0]    pendPast_ff;
  logic                   lowValid;
  logic [DIPS_CHW-1:0]    lowIdx;
  logic                   addrTake;
  logic                   sumWr;
  logic [DIPS_CHW-1:0]    wrId;
  logic [15:0]            sumView;
  logic [31:0]            rdMux;
  logic [DIPS_NEV-1:0]    evHit;

  // ----------------------------------------------------------------
  // AHB-Lite slave
  // ----------------------------------------------------------------
  // Zero wait states; hsize is not checked since only whole words are mapped
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_ff;
  assign addrTake  = hsel && hready && htrans[1];

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      aph_ff <= '0;
    end else if (hready) begin
      aph_ff.valid <= addrTake;
      aph_ff.write <= hwrite;
      aph_ff.addr  <= haddr[7:0];
    end
  end

  assign sumWr = wrHit(aph_ff, DIPS_ADDR_SUMMARY);
  // A clearing write acts on the channel it selects in the same word
  assign wrId  = hwdata[DIPS_ID_LSB +: DIPS_CHW];

  // ----------------------------------------------------------------
  // Summary view of the selected channel
  // ----------------------------------------------------------------
  assign pendVec = flags_ff.crc | flags_ff.suspend_irq_flag | flags_ff.transfer_done_flag | flags_ff.transfer_fault_flag;

  always_comb begin
    sumView                              = DIPS_SUMMARY_RST;
    sumView[DIPS_BIT_CHANNEL_PENDING_FLAG]               = pendVec[id_ff];
    sumView[DIPS_BIT_BUSY]               = chanBusy[id_ff];
    sumView[DIPS_BIT_DESCRIPTOR_FETCH_ERROR_FLAG]               = chanFetchErr[id_ff];
    sumView[DIPS_BIT_CRC]                = flags_ff.crc[id_ff];
    sumView[DIPS_BIT_SUSPEND_IRQ_FLAG]               = flags_ff.suspend_irq_flag[id_ff];
    sumView[DIPS_BIT_TRANSFER_DONE_FLAG]              = flags_ff.transfer_done_flag[id_ff];
    sumView[DIPS_BIT_TRANSFER_FAULT_FLAG]               = flags_ff.transfer_fault_flag[id_ff];
    sumView[DIPS_ID_LSB +: DIPS_CHW]     = id_ff;
  end

  dips_lowest_finder i_dips_lowest_finder (
    .pendVec  (pendVec),
    .lowValid (lowValid),
    .lowIdx   (lowIdx)
  );

  // ----------------------------------------------------------------
  // Read data, captured in the address phase
  // ----------------------------------------------------------------
  // Limitation: a read whose address phase overlaps a write data phase sees pre-write state
  always_comb begin
    rdMux = DIPS_ZERO32;
    unique case (haddr[7:0])
      DIPS_ADDR_SUMMARY: rdMux[15:0] = sumView;
      DIPS_ADDR_LOWEST: begin
        rdMux[DIPS_BIT_LOWVALID]          = lowValid;
        rdMux[DIPS_ID_LSB +: DIPS_CHW]    = lowIdx;
      end
      DIPS_ADDR_EVSTAT:  rdMux[DIPS_NEV-1:0] = evStat_ff;
      DIPS_ADDR_EVEN:    rdMux[DIPS_NEV-1:0] = evEn_ff;
      default:           rdMux = DIPS_ZERO32;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      hrdata_ff <= DIPS_ZERO32;
    end else if (addrTake && !hwrite) begin
      hrdata_ff <= rdMux;
    end
  end

  // ----------------------------------------------------------------
  // Channel select field
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      id_ff <= DIPS_ID_RST;
    end else if (sumWr) begin
      id_ff <= wrId;
    end
  end

  // ----------------------------------------------------------------
  // Per-channel interrupt flags
  // ----------------------------------------------------------------
  always_comb begin
    nxt_flags.crc   = nextFlags(flags_ff.crc, chanSet.crc,
                                chanClr.crc | oneHot(sumWr && hwdata[DIPS_BIT_CRC], wrId));
    nxt_flags.suspend_irq_flag  = nextFlags(flags_ff.suspend_irq_flag, chanSet.suspend_irq_flag,
                                chanClr.suspend_irq_flag | oneHot(sumWr && hwdata[DIPS_BIT_SUSPEND_IRQ_FLAG], wrId));
    nxt_flags.transfer_done_flag = nextFlags(flags_ff.transfer_done_flag, chanSet.transfer_done_flag,
                                chanClr.transfer_done_flag | oneHot(sumWr && hwdata[DIPS_BIT_TRANSFER_DONE_FLAG], wrId));
    nxt_flags.transfer_fault_flag  = nextFlags(flags_ff.transfer_fault_flag, chanSet.transfer_fault_flag,
                                chanClr.transfer_fault_flag | oneHot(sumWr && hwdata[DIPS_BIT_TRANSFER_FAULT_FLAG], wrId));
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      flags_ff <= '0;
    end else begin
      flags_ff <= nxt_flags;
    end
  end

  assign chanFlags = flags_ff;

  // ----------------------------------------------------------------
  // Event status, write-one clear and enable
  // ----------------------------------------------------------------
  assign evHit[DIPS_EV_CRC]   = |chanSet.crc;
  assign evHit[DIPS_EV_SUSPEND_IRQ_FLAG]  = |chanSet.suspend_irq_flag;
  assign evHit[DIPS_EV_TRANSFER_DONE_FLAG] = |chanSet.transfer_done_flag;
  assign evHit[DIPS_EV_TRANSFER_FAULT_FLAG]  = |chanSet.transfer_fault_flag;

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      evStat_ff <= DIPS_EV_RST;
    end else if (wrHit(aph_ff, DIPS_ADDR_EVCLR)) begin
      evStat_ff <= (evStat_ff & ~hwdata[DIPS_NEV-1:0]) | evHit;
    end else begin
      evStat_ff <= evStat_ff | evHit;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      evEn_ff <= DIPS_EV_RST;
    end else if (wrHit(aph_ff, DIPS_ADDR_EVEN)) begin
      evEn_ff <= hwdata[DIPS_NEV-1:0];
    end
  end

  assign irq = |(evStat_ff & evEn_ff);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_sumRead;
    addrTake && !hwrite && (haddr[7:0] == DIPS_ADDR_SUMMARY);
  endsequence

  sequence s_lowRead;
    addrTake && !hwrite && (haddr[7:0] == DIPS_ADDR_LOWEST);
  endsequence

  // Pending vector as it stood when a read was captured; the locator check
  // must index it with the channel read back, not with an older one
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      pendPast_ff <= '0;
    end else begin
      pendPast_ff <= pendVec;
    end
  end

  property p_lowest;
    @(posedge mclk) disable iff (!rst_b)
      s_lowRead |=> (hrdata[DIPS_BIT_LOWVALID] == (pendPast_ff != '0)) &&
        (!hrdata[DIPS_BIT_LOWVALID] || (pendPast_ff[hrdata[DIPS_ID_LSB +: DIPS_CHW]] &&
        ((pendPast_ff & ((DIPS_NCH'(1) << hrdata[DIPS_ID_LSB +: DIPS_CHW]) - DIPS_NCH'(1))) == '0)));
  endproperty
  a_lowest: assert property (p_lowest) else $error("lowest pending channel wrong");

  property p_pendRead;
    @(posedge mclk) disable iff (!rst_b)
      s_sumRead |=> hrdata[DIPS_BIT_CHANNEL_PENDING_FLAG] == $past(pendVec[id_ff]);
  endproperty
  a_pendRead: assert property (p_pendRead) else $error("pending bit mismatch");

  property p_busyRead;
    @(posedge mclk) disable iff (!rst_b)
      s_sumRead |=> hrdata[DIPS_BIT_BUSY] == $past(chanBusy[id_ff]);
  endproperty
  a_busyRead: assert property (p_busyRead) else $error("busy bit mismatch");

  property p_ferrRead;
    @(posedge mclk) disable iff (!rst_b)
      s_sumRead |=> hrdata[DIPS_BIT_DESCRIPTOR_FETCH_ERROR_FLAG] == $past(chanFetchErr[id_ff]);
  endproperty
  a_ferrRead: assert property (p_ferrRead) else $error("fetch error bit mismatch");

  property p_crcSet;
    @(posedge mclk) disable iff (!rst_b)
      chanSet.crc[id_ff] && !sumWr |=> sumView[DIPS_BIT_CRC];
  endproperty
  a_crcSet: assert property (p_crcSet) else $error("crc fault not shown");

  property p_crcClear;
    @(posedge mclk) disable iff (!rst_b)
      sumWr && hwdata[DIPS_BIT_CRC] && !chanSet.crc[wrId] |=> !flags_ff.crc[$past(wrId)] && !sumView[DIPS_BIT_CRC];
  endproperty
  a_crcClear: assert property (p_crcClear) else $error("crc write one did not clear");

  property p_suspKeep;
    @(posedge mclk) disable iff (!rst_b)
      sumWr && !hwdata[DIPS_BIT_SUSPEND_IRQ_FLAG] && flags_ff.suspend_irq_flag[wrId] && !chanClr.suspend_irq_flag[wrId] |=> flags_ff.suspend_irq_flag[$past(wrId)];
  endproperty
  a_suspKeep: assert property (p_suspKeep) else $error("suspend write zero changed flag");

  property p_suspRead;
    @(posedge mclk) disable iff (!rst_b)
      s_sumRead |=> hrdata[DIPS_BIT_SUSPEND_IRQ_FLAG] == $past(flags_ff.suspend_irq_flag[id_ff]);
  endproperty
  a_suspRead: assert property (p_suspRead) else $error("suspend bit mismatch");

  property p_tcmplKeep;
    @(posedge mclk) disable iff (!rst_b)
      sumWr && !hwdata[DIPS_BIT_TRANSFER_DONE_FLAG] && flags_ff.transfer_done_flag[wrId] && !chanClr.transfer_done_flag[wrId] |=> flags_ff.transfer_done_flag[$past(wrId)];
  endproperty
  a_tcmplKeep: assert property (p_tcmplKeep) else $error("transfer done write zero changed flag");

  property p_terrClear;
    @(posedge mclk) disable iff (!rst_b)
      sumWr && hwdata[DIPS_BIT_TRANSFER_FAULT_FLAG] && !chanSet.transfer_fault_flag[wrId] ##1 s_sumRead |=> !hrdata[DIPS_BIT_TRANSFER_FAULT_FLAG];
  endproperty
  a_terrClear: assert property (p_terrClear) else $error("transfer fault write one did not clear");

  property p_crcRead;
    @(posedge mclk) disable iff (!rst_b)
      s_sumRead |=> hrdata[DIPS_BIT_CRC] == $past(flags_ff.crc[id_ff]);
  endproperty
  a_crcRead: assert property (p_crcRead) else $error("crc fault bit mismatch");

  property p_suspClear;
    @(posedge mclk) disable iff (!rst_b)
      sumWr && hwdata[DIPS_BIT_SUSPEND_IRQ_FLAG] && !chanSet.suspend_irq_flag[wrId] |=> !flags_ff.suspend_irq_flag[$past(wrId)];
  endproperty
  a_suspClear: assert property (p_suspClear) else $error("suspend write one did not clear");

  property p_tcmplRead;
    @(posedge mclk) disable iff (!rst_b)
      s_sumRead |=> hrdata[DIPS_BIT_TRANSFER_DONE_FLAG] == $past(flags_ff.transfer_done_flag[id_ff]);
  endproperty
  a_tcmplRead: assert property (p_tcmplRead) else $error("transfer done bit mismatch");

  property p_terrKeep;
    @(posedge mclk) disable iff (!rst_b)
      sumWr && !hwdata[DIPS_BIT_TRANSFER_FAULT_FLAG] && flags_ff.transfer_fault_flag[wrId] && !chanClr.transfer_fault_flag[wrId] |=> flags_ff.transfer_fault_flag[$past(wrId)];
  endproperty
  a_terrKeep: assert property (p_terrKeep) else $error("transfer fault write zero changed flag");

  property p_evSet;
    @(posedge mclk) disable iff (!rst_b)
      (chanSet.crc != '0) |=> evStat_ff[DIPS_EV_CRC];
  endproperty
  a_evSet: assert property (p_evSet) else $error("crc event not latched");

endmodule
`default_nettype wire

// File: rtl/dips_pkg.sv
/*
  Constants, field layout and carrier types for the DMA pending-summary block.
  Assumes a 32-channel DMA engine on the same clock and an AHB-Lite bus with 32-bit data.
*/
// Function
// - Software can find the lowest pending channel
// - Bit 15 shows selected channel pending
// - Bit 14 shows selected channel busy, read-only
// - Bit 13 shows selected channel descriptor fetch error
// - Bit 12 shows selected channel CRC fault
// - Write one clears CRC/suspend bit and flag
// - Bit 10 shows selected channel suspend pending
// - Bit 9 shows transfer done; zero ignored
package dips_pkg;

  localparam int unsigned DIPS_NCH = 32;
  localparam int unsigned DIPS_CHW = 5;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] DIPS_ADDR_SUMMARY = 8'h20;
  localparam logic [7:0] DIPS_ADDR_LOWEST  = 8'h24;
  localparam logic [7:0] DIPS_ADDR_EVSTAT  = 8'h28;
  localparam logic [7:0] DIPS_ADDR_EVCLR   = 8'h2C;
  localparam logic [7:0] DIPS_ADDR_EVEN    = 8'h30;

  // ----------------------------------------------------------------
  // Summary register fields
  // ----------------------------------------------------------------
  localparam int unsigned DIPS_BIT_CHANNEL_PENDING_FLAG  = 15;
  localparam int unsigned DIPS_BIT_BUSY  = 14;
  localparam int unsigned DIPS_BIT_DESCRIPTOR_FETCH_ERROR_FLAG  = 13;
  localparam int unsigned DIPS_BIT_CRC   = 12;
  localparam int unsigned DIPS_BIT_SUSPEND_IRQ_FLAG  = 10;
  localparam int unsigned DIPS_BIT_TRANSFER_DONE_FLAG = 9;
  localparam int unsigned DIPS_BIT_TRANSFER_FAULT_FLAG  = 8;
  localparam int unsigned DIPS_ID_LSB    = 0;
  localparam logic [15:0] DIPS_SUMMARY_RST = 16'h0000;
  localparam logic [4:0]  DIPS_ID_RST      = 5'h00;

  // Lowest-pending register: channel number low, valid flag above
  localparam int unsigned DIPS_BIT_LOWVALID = 8;

  // ----------------------------------------------------------------
  // Event status, clear and enable layout
  // ----------------------------------------------------------------
  localparam int unsigned DIPS_NEV        = 4;
  localparam int unsigned DIPS_EV_CRC     = 0;
  localparam int unsigned DIPS_EV_SUSPEND_IRQ_FLAG    = 1;
  localparam int unsigned DIPS_EV_TRANSFER_DONE_FLAG   = 2;
  localparam int unsigned DIPS_EV_TRANSFER_FAULT_FLAG    = 3;
  localparam logic [3:0]  DIPS_EV_RST     = 4'h0;

  localparam logic [31:0] DIPS_ZERO32 = 32'h0000_0000;
  localparam logic [1:0]  DIPS_HTRANS_IDLE = 2'h0;

  // Per-channel flag vectors, one bit per channel for each interrupt kind
  typedef struct packed {
    logic [DIPS_NCH-1:0] crc;
    logic [DIPS_NCH-1:0] suspend_irq_flag;
    logic [DIPS_NCH-1:0] transfer_done_flag;
    logic [DIPS_NCH-1:0] transfer_fault_flag;
  } dips_chvec_t;

  // Captured AHB address phase
  typedef struct packed {
    logic       valid;
    logic       write;
    logic [7:0] addr;
  } dips_aphase_t;

endpackage

// File: rtl/dips_lowest_finder.sv
/*
  Priority encoder: lowest set bit of the per-channel pending vector.
  Assumes a combinational path is acceptable; the result is registered by the caller.
*/
`timescale 1ns/1ps
`default_nettype none
module dips_lowest_finder
  import dips_pkg::*;
(
  input  wire logic [dips_pkg::DIPS_NCH-1:0] pendVec,
  output logic                               lowValid,
  output logic [dips_pkg::DIPS_CHW-1:0]      lowIdx
);

  always_comb begin
    lowValid = 1'b0;
    lowIdx   = '0;
    // Scan downward so the lowest set bit wins
    for (int i = DIPS_NCH - 1; i >= 0; i--) begin
      if (pendVec[i]) begin
        lowValid = 1'b1;
        lowIdx   = DIPS_CHW'(i);
      end
    end
  end

endmodule
`default_nettype wire

// File: tb/test_dips_top.sv
/*
  Self-checking testbench for the DMA pending-summary block.
  Assumes the design's single slave answers with hreadyout, which is fed back as hready.
*/
`timescale 1ns/1ps
`default_nettype none
module test_dips_top;
  import dips_pkg::*;

  logic                mclk;
  logic                rst_b;
  logic                hsel;
  logic                hwrite;
  logic [31:0]         haddr;
  logic [31:0]         hwdata;
  logic [31:0]         hrdata;
  logic [1:0]          htrans;
  logic                hreadyout;
  logic                hresp;
  logic                irq;
  logic [DIPS_NCH-1:0] chanBusy;
  logic [DIPS_NCH-1:0] chanFetchErr;
  dips_chvec_t         chanSet;
  dips_chvec_t         chanClr;
  dips_chvec_t         chanFlags;
  int                  nFail;
  int                  totalChecks;

  dips_top i_dips_top (
    .mclk(mclk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .chanSet(chanSet), .chanClr(chanClr), .chanBusy(chanBusy),
    .chanFetchErr(chanFetchErr), .chanFlags(chanFlags), .irq(irq)
  );

  always #5 mclk = ~mclk;

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    totalChecks++;
    if (got !== exp) begin
      nFail++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Entered just after a rising edge; waits on hready, never on a fixed count
  task automatic busXfer(input logic [7:0] a, input logic wr, input logic [31:0] d, output logic [31:0] r);
    int n;
    hsel   <= 1'b1;
    haddr  <= {24'h00_0000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    n = 0;
    do begin @(posedge mclk); n++; end while (hreadyout !== 1'b1 && n < 100);
    hsel   <= 1'b0;
    htrans <= DIPS_HTRANS_IDLE;
    hwdata <= wr ? d : DIPS_ZERO32;
    n = 0;
    do begin @(posedge mclk); n++; end while (hreadyout !== 1'b1 && n < 100);
    r = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] unused;
    busXfer(a, 1'b1, d, unused);
  endtask

  task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    busXfer(a, 1'b0, DIPS_ZERO32, v);
    chk(v, exp, "register read");
  endtask

  task automatic pulseSet(input dips_chvec_t v);
    chanSet <= v;
    @(posedge mclk);
    chanSet <= '0;
    @(posedge mclk);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic testReset();
    chk({30'h0, hreadyout, hresp}, 32'h0000_0002, "ready and response");
    rdChk(DIPS_ADDR_SUMMARY, 32'h0000_0000);
    rdChk(DIPS_ADDR_LOWEST, 32'h0000_0000);
    rdChk(DIPS_ADDR_EVSTAT, 32'h0000_0000);
    rdChk(8'h40, 32'h0000_0000);
    chk({31'h0, irq}, 32'h0000_0000, "irq after reset");
  endtask

  task automatic testSummary();
    dips_chvec_t v;
    logic [31:0] exp;
    v = '0;
    v.crc[5] = 1'b1;
    chanBusy[5]     <= 1'b1;
    chanFetchErr[5] <= 1'b1;
    pulseSet(v);
    wr(DIPS_ADDR_SUMMARY, 32'h0000_0005);
    rdChk(DIPS_ADDR_SUMMARY, 32'h0000_F005);
    rdChk(DIPS_ADDR_LOWEST, 32'h0000_0105);
    v = '0;
    v.transfer_done_flag[3] = 1'b1;
    pulseSet(v);
    rdChk(DIPS_ADDR_LOWEST, 32'h0000_0103);
    wr(DIPS_ADDR_SUMMARY, 32'h0000_0203);
    rdChk(DIPS_ADDR_LOWEST, 32'h0000_0105);
    v = '0;
    v.suspend_irq_flag[5]  = 1'b1;
    v.transfer_done_flag[5] = 1'b1;
    v.transfer_fault_flag[5]  = 1'b1;
    pulseSet(v);
    // Writing zeros to the clearable bits must leave every flag standing
    wr(DIPS_ADDR_SUMMARY, 32'h0000_0005);
    rdChk(DIPS_ADDR_SUMMARY, 32'h0000_F705);
    exp = 32'h0000_F705;
    clearOne(DIPS_BIT_CRC, exp);
    clearOne(DIPS_BIT_SUSPEND_IRQ_FLAG, exp);
    clearOne(DIPS_BIT_TRANSFER_DONE_FLAG, exp);
    clearOne(DIPS_BIT_TRANSFER_FAULT_FLAG, exp);
    chk({31'h0, |chanFlags}, 32'h0000_0000, "flags after clears");
    rdChk(DIPS_ADDR_SUMMARY, 32'h0000_6005);
    rdChk(DIPS_ADDR_LOWEST, 32'h0000_0000);
  endtask

  task automatic clearOne(input int unsigned b, inout logic [31:0] exp);
    wr(DIPS_ADDR_SUMMARY, (32'h0000_0001 << b) | 32'h0000_0005);
    exp = exp & ~(32'h0000_0001 << b);
    if (exp[12] === 1'b0 && exp[10:8] === 3'h0) begin
      exp[15] = 1'b0;
    end
    rdChk(DIPS_ADDR_SUMMARY, exp);
  endtask

  task automatic testExternalClear();
    dips_chvec_t v;
    v = '0;
    v.suspend_irq_flag[7] = 1'b1;
    pulseSet(v);
    chk({31'h0, chanFlags.suspend_irq_flag[7]}, 32'h0000_0001, "suspend flag set");
    chanClr <= v;
    @(posedge mclk);
    chanClr <= '0;
    @(posedge mclk);
    chk({31'h0, chanFlags.suspend_irq_flag[7]}, 32'h0000_0000, "suspend flag cleared");
  endtask

  task automatic testIrq();
    rdChk(DIPS_ADDR_EVSTAT, 32'h0000_000F);
    chk({31'h0, irq}, 32'h0000_0000, "irq masked");
    wr(DIPS_ADDR_EVEN, 32'h0000_0004);
    @(posedge mclk);
    chk({31'h0, irq}, 32'h0000_0001, "irq enabled");
    rdChk(DIPS_ADDR_EVEN, 32'h0000_0004);
    wr(DIPS_ADDR_EVCLR, 32'h0000_0004);
    @(posedge mclk);
    chk({31'h0, irq}, 32'h0000_0000, "irq after clear");
    rdChk(DIPS_ADDR_EVSTAT, 32'h0000_000B);
    rdChk(DIPS_ADDR_EVCLR, 32'h0000_0000);
    wr(DIPS_ADDR_EVEN, 32'h0000_0000);
  endtask

  task automatic endOfTest();
    if (nFail == 0 && totalChecks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    rst_b = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    haddr = DIPS_ZERO32;
    hwdata = DIPS_ZERO32;
    htrans = DIPS_HTRANS_IDLE;
    chanSet = '0;
    chanClr = '0;
    chanBusy = '0;
    chanFetchErr = '0;
    nFail = 0;
    totalChecks = 0;
    repeat (12) @(posedge mclk);
    rst_b <= 1'b1;
    @(posedge mclk);
    testReset();
    testSummary();
    testExternalClear();
    testIrq();
    endOfTest();
  end

  // The whole sequence needs under a hundred cycles; this bound only catches a hang
  initial begin
    repeat (5000) @(posedge mclk);
    nFail++;
    endOfTest();
  end

endmodule
`default_nettype wire
